// file: include/i2c_ctrl_consts.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  I2C address match, SCL generator and control clear block.
  Assumes inclusion by bare name from files built with include/ on the path.
*/
`ifndef I2C_CTRL_CONSTS_SVH
`define I2C_CTRL_CONSTS_SVH

// register byte addresses
`define CTRL_SET_ADDR 32'h4000_0000
`define SLAVE_ADDR0_ADDR 32'h4000_000C
`define SCL_HIGH_ADDR 32'h4000_0010
`define SCL_LOW_ADDR 32'h4000_0014
`define CTRL_CLEAR_ADDR 32'h4000_0018
`define IRQ_STATUS_ADDR 32'h4000_0030
`define IRQ_ENABLE_ADDR 32'h4000_0034
`define IRQ_CLEAR_ADDR 32'h4000_0038

// control flag bit positions, shared by set and readback; clear uses all but the stop request bit
`define ACK_ASSERT_BIT 2
`define IRQ_FLAG_BIT 3
`define STOP_REQ_BIT 4
`define START_REQ_BIT 5
`define IFACE_EN_BIT 6

// slave address register fields
`define GEN_CALL_BIT 0
`define ADDR_MSB 7
`define ADDR_LSB 1
`define GEN_CALL_ADDR 7'h00

// interrupt status bit positions
`define EV_OWN_ADDR 0
`define EV_GEN_CALL 1
`define EV_IRQ_FLAG 2
`define EV_WIDTH 3

// reset values and minimum SCL period
`define SLAVE_ADDR_RESET 8'h00
`define SCL_PERIOD_RESET 16'h0004
`define SCL_PERIOD_MIN 16'h0004

// clock
`define CLOCK_PERIOD_NS 10

`endif

// file: include/i2c_ctrl_pkg.sv
/*
  Types of the I2C address match, SCL generator and control clear block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package i2c_ctrl_pkg;

  typedef logic [15:0] period_t;
  typedef logic [7:0] slave_addr_t;
  typedef logic [31:0] word_t;

  // gray along idle -> low -> high -> low
  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_LOW = 2'b01,
    SCL_HIGH = 2'b11
  } scl_state_t;

  function automatic period_t reload_of(input period_t p);
    reload_of = (p == 16'h0000) ? 16'h0000 : p - 16'h0001;
  endfunction : reload_of

endpackage : i2c_ctrl_pkg

// file: src/scl_phase_gen.sv
/*
  SCL bit-rate generator: times low and high phases from programmable counts.
  Assumes a single clock, synchronous active-high reset and an open-drain SCL
  whose level is resolved outside from the active-low output enable.
*/
`timescale 1ns/1ps
`default_nettype none

module scl_phase_gen
  import i2c_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // control
  input wire logic i_run,
  input wire logic i_hold_low,
  input wire i2c_ctrl_pkg::period_t i_high_count,
  input wire i2c_ctrl_pkg::period_t i_low_count,
  // line
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe_n
);
  import i2c_ctrl_pkg::*;

  scl_state_t state_r;
  period_t count_r;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= SCL_IDLE;
      count_r <= 16'h0000;
      o_scl_oe_n <= 1'b1;
    end else if (!i_run) begin
      state_r <= SCL_IDLE;
      count_r <= 16'h0000;
      o_scl_oe_n <= 1'b1;
    end else begin
      case (state_r)
        SCL_IDLE: begin
          state_r <= SCL_LOW;
          count_r <= reload_of(i_low_count);
          o_scl_oe_n <= 1'b0;
        end
        SCL_LOW: begin
          if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
          end else if (!i_hold_low) begin
            state_r <= SCL_HIGH;
            count_r <= reload_of(i_high_count);
            o_scl_oe_n <= 1'b1;
          end
        end
        SCL_HIGH: begin
          // other parties may stretch; high time counts only once the line is up
          if (i_scl_in) begin
            if (count_r != 16'h0000) begin
              count_r <= count_r - 16'h0001;
            end else begin
              state_r <= SCL_LOW;
              count_r <= reload_of(i_low_count);
              o_scl_oe_n <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= SCL_IDLE;
          count_r <= 16'h0000;
          o_scl_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge i_clock) begin
    o_scl_out <= 1'b0;
  end

endmodule : scl_phase_gen

`default_nettype wire

// file: src/i2c_ctrl_top.sv
/*
  I2C slave address match, SCL rate generation and control flag set/clear,
  with a register port and a level interrupt.
  Assumes the transfer engine outside supplies received address bytes,
  master mode, state-change and stop events, and reads the control flags.
*/
// Notes on behaviour
// - general-call bit set makes address 0x00 address this device
// - slave address register bits 7:1 hold the seven-bit own address
// - address recognition only in slave operation, never as master
// - slave address register of 0x00 acknowledges no address
// - reset clears the slave address registers, recognition off
// - high count gives clock cycles SCL is released high, reset 0x0004
// - low count gives clock cycles SCL is driven low, reset 0x0004
// - bit rate is clock frequency over high plus low count
// - high and low counts may differ for asymmetric duty cycle
// - clear register clears flags written one except stop request bit 4; clear bit 6 also drops the stop flag
// - clear bit 2 clears the acknowledge-assert flag
// - clear bit 3 clears the interrupt flag
// - clear bit 5 clears the start request flag
// - clear bit 6 clears interface enable, disabling the interface
// - interrupt flag set stretches SCL low; high SCL unaffected
// - disabled: bus inputs ignored, not addressed, stop flag forced zero
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.svh"

module i2c_ctrl_top
  import i2c_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // register port
  input wire i2c_ctrl_pkg::word_t i_addr,
  input wire i2c_ctrl_pkg::word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output i2c_ctrl_pkg::word_t o_rdata,
  // interrupt
  output logic o_irq,
  // transfer engine side
  input wire logic i_master_mode,
  input wire logic i_clock_run,
  input wire logic i_addr_valid,
  input wire logic [7:0] i_addr_byte,
  input wire logic i_state_change,
  input wire logic i_stop_seen,
  output logic o_ack_flag,
  output logic o_irq_flag,
  output logic o_start_flag,
  output logic o_stop_flag,
  output logic o_iface_en,
  output logic o_addr_hit,
  output logic o_gc_hit,
  output logic o_ack_addr,
  output logic o_addressed,
  // serial clock pin
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe_n
);
  import i2c_ctrl_pkg::*;

  slave_addr_t slave_addr_r;
  period_t high_r;
  period_t low_r;
  logic [`EV_WIDTH-1:0] ev_status_r;
  logic [`EV_WIDTH-1:0] ev_enable_r;
  logic [`EV_WIDTH-1:0] ev_set;
  logic wr_set;
  logic wr_clear;
  logic wr_irq_clear;
  logic own_match;
  logic gc_match;
  logic byte_seen;
  word_t rdata_nxt;

  assign wr_set = i_wr && (i_addr == `CTRL_SET_ADDR);
  assign wr_clear = i_wr && (i_addr == `CTRL_CLEAR_ADDR);
  assign wr_irq_clear = i_wr && (i_addr == `IRQ_CLEAR_ADDR);

  // disabled interface ignores the bus; master ignores the address register
  assign byte_seen = i_addr_valid && o_iface_en && !i_master_mode;
  assign own_match = byte_seen && (slave_addr_r != `SLAVE_ADDR_RESET)
    && (slave_addr_r[`ADDR_MSB:`ADDR_LSB] != `GEN_CALL_ADDR)
    && (i_addr_byte[`ADDR_MSB:`ADDR_LSB] == slave_addr_r[`ADDR_MSB:`ADDR_LSB]);
  assign gc_match = byte_seen && slave_addr_r[`GEN_CALL_BIT]
    && (i_addr_byte[`ADDR_MSB:`ADDR_LSB] == `GEN_CALL_ADDR);

  // configuration registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      slave_addr_r <= `SLAVE_ADDR_RESET;
      high_r <= `SCL_PERIOD_RESET;
      low_r <= `SCL_PERIOD_RESET;
      ev_enable_r <= '0;
    end else if (i_wr) begin
      case (i_addr)
        `SLAVE_ADDR0_ADDR: slave_addr_r <= i_wdata[7:0];
        `SCL_HIGH_ADDR: high_r <= i_wdata[15:0];
        `SCL_LOW_ADDR: low_r <= i_wdata[15:0];
        `IRQ_ENABLE_ADDR: ev_enable_r <= i_wdata[`EV_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // acknowledge-assert flag
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ack_flag <= 1'b0;
    end else if (wr_set && i_wdata[`ACK_ASSERT_BIT]) begin
      o_ack_flag <= 1'b1;
    end else if (wr_clear && i_wdata[`ACK_ASSERT_BIT]) begin
      o_ack_flag <= 1'b0;
    end
  end

  // interrupt flag: a state change wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_irq_flag <= 1'b0;
    end else if ((i_state_change && o_iface_en) || (wr_set && i_wdata[`IRQ_FLAG_BIT])) begin
      o_irq_flag <= 1'b1;
    end else if (wr_clear && i_wdata[`IRQ_FLAG_BIT]) begin
      o_irq_flag <= 1'b0;
    end
  end

  // start request flag
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_start_flag <= 1'b0;
    end else if (wr_set && i_wdata[`START_REQ_BIT]) begin
      o_start_flag <= 1'b1;
    end else if (wr_clear && i_wdata[`START_REQ_BIT]) begin
      o_start_flag <= 1'b0;
    end
  end

  // interface enable flag
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_iface_en <= 1'b0;
    end else if (wr_set && i_wdata[`IFACE_EN_BIT]) begin
      o_iface_en <= 1'b1;
    end else if (wr_clear && i_wdata[`IFACE_EN_BIT]) begin
      o_iface_en <= 1'b0;
    end
  end

  // stop request flag: cleared by a seen stop, held at zero while disabled
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_stop_flag <= 1'b0;
    end else if (!o_iface_en || (wr_clear && i_wdata[`IFACE_EN_BIT])) begin
      o_stop_flag <= 1'b0;
    end else if (wr_set && i_wdata[`STOP_REQ_BIT]) begin
      o_stop_flag <= 1'b1;
    end else if (i_stop_seen) begin
      o_stop_flag <= 1'b0;
    end
  end

  // address recognition results
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_addr_hit <= 1'b0;
      o_gc_hit <= 1'b0;
      o_ack_addr <= 1'b0;
    end else begin
      o_addr_hit <= own_match;
      o_gc_hit <= gc_match;
      o_ack_addr <= (own_match || gc_match) && o_ack_flag;
    end
  end

  // addressed slave state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_addressed <= 1'b0;
    end else if (!o_iface_en || i_master_mode) begin
      o_addressed <= 1'b0;
    end else if ((own_match || gc_match) && o_ack_flag) begin
      o_addressed <= 1'b1;
    end else if (i_stop_seen || (wr_set && i_wdata[`STOP_REQ_BIT])) begin
      o_addressed <= 1'b0;
    end
  end

  // sticky event status, set wins over clear
  assign ev_set = {o_iface_en && i_state_change, gc_match, own_match};

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ev_status_r <= '0;
    end else if (wr_irq_clear) begin
      ev_status_r <= (ev_status_r & ~i_wdata[`EV_WIDTH-1:0]) | ev_set;
    end else begin
      ev_status_r <= ev_status_r | ev_set;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ev_status_r & ev_enable_r);
    end
  end

  // register read, data in the next cycle
  always_comb begin
    rdata_nxt = '0;
    case (i_addr)
      `CTRL_SET_ADDR: begin
        rdata_nxt[`ACK_ASSERT_BIT] = o_ack_flag;
        rdata_nxt[`IRQ_FLAG_BIT] = o_irq_flag;
        rdata_nxt[`STOP_REQ_BIT] = o_stop_flag;
        rdata_nxt[`START_REQ_BIT] = o_start_flag;
        rdata_nxt[`IFACE_EN_BIT] = o_iface_en;
      end
      `SLAVE_ADDR0_ADDR: rdata_nxt[7:0] = slave_addr_r;
      `SCL_HIGH_ADDR: rdata_nxt[15:0] = high_r;
      `SCL_LOW_ADDR: rdata_nxt[15:0] = low_r;
      `IRQ_STATUS_ADDR: rdata_nxt[`EV_WIDTH-1:0] = ev_status_r;
      `IRQ_ENABLE_ADDR: rdata_nxt[`EV_WIDTH-1:0] = ev_enable_r;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= '0;
    end
  end

  scl_phase_gen u_scl_gen (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_run(i_clock_run && o_iface_en && i_master_mode),
    .i_hold_low(o_irq_flag),
    .i_high_count(high_r),
    .i_low_count(low_r),
    .i_scl_in(i_scl_in && o_iface_en),
    .o_scl_out(o_scl_out),
    .o_scl_oe_n(o_scl_oe_n)
  );

  // checking helpers: length of the last low phase, and whether it was disturbed
  period_t low_len_r;
  logic low_disturbed_r;

  always_ff @(posedge i_clock) begin
    if (i_reset || o_scl_oe_n) begin
      low_len_r <= 16'h0000;
      low_disturbed_r <= 1'b0;
    end else begin
      low_len_r <= low_len_r + 16'h0001;
      low_disturbed_r <= low_disturbed_r || o_irq_flag || !i_clock_run
        || !o_iface_en || !i_master_mode || (i_wr && (i_addr == `SCL_LOW_ADDR));
    end
  end

  a_gc_recognised: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_addr_valid && o_iface_en && !i_master_mode && slave_addr_r[0]
      && (i_addr_byte[7:1] == 7'h00)) |=> o_gc_hit)
    else $error("general call not recognised");

  a_own_addr_match: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_addr_valid && o_iface_en && !i_master_mode && (slave_addr_r[7:1] != 7'h00)
      && (i_addr_byte[7:1] == slave_addr_r[7:1])) |=> o_addr_hit)
    else $error("own address not matched");

  a_master_no_match: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_master_mode |=> !o_addr_hit && !o_gc_hit && !o_addressed)
    else $error("address recognised in master operation");

  a_zero_addr_silent: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (slave_addr_r == 8'h00) |=> !o_addr_hit && !o_gc_hit && !o_ack_addr)
    else $error("disabled address register acknowledged");

  a_reset_defaults: assert property (
    @(posedge i_clock)
    $past(i_reset) && !i_reset |-> (slave_addr_r == 8'h00) && (high_r == 16'h0004)
      && (low_r == 16'h0004))
    else $error("wrong reset values");

  a_low_phase_len: assert property (
    @(posedge i_clock) disable iff (i_reset)
    $rose(o_scl_oe_n) && !$past(low_disturbed_r) && ($past(low_r) >= 16'h0001)
      |-> ($past(low_len_r) + 16'h0001 == $past(low_r)))
    else $error("scl low phase length wrong");

  a_irq_stretch_low: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_scl_oe_n && o_irq_flag && i_clock_run && o_iface_en && i_master_mode
      |=> !o_scl_oe_n)
    else $error("scl released while interrupt flag set");

  a_clear_ack_flag: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_wr && (i_addr == 32'h4000_0018) && i_wdata[2] |=> !o_ack_flag)
    else $error("ack flag not cleared");

  a_clear_zero_keeps: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_wr && (i_addr == 32'h4000_0018) && !i_wdata[5] |=> $stable(o_start_flag))
    else $error("clear of zero bit changed start flag");

  a_clear_irq_flag: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_wr && (i_addr == 32'h4000_0018) && i_wdata[3] && !i_state_change |=> !o_irq_flag)
    else $error("interrupt flag not cleared");

  a_clear_start_en: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_wr && (i_addr == 32'h4000_0018) && i_wdata[5] && i_wdata[6]
      |=> !o_start_flag && !o_iface_en ##1 !o_stop_flag)
    else $error("start or enable flag not cleared");

  a_disabled_idle: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_iface_en ##1 !o_iface_en |-> !o_stop_flag && !o_addressed && o_scl_oe_n)
    else $error("disabled interface not idle");

endmodule : i2c_ctrl_top

`default_nettype wire

// file: tb/scl_partner.sv
/*
  Far side of the serial clock: pull-up on SCL, wired-and with the device's
  open-drain drive, and a slave that can stretch the start of a high phase.
  Assumes the device pulls SCL low while its active-low output enable is 0.
*/
`timescale 1ns/1ps
`default_nettype none

module scl_partner (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // device drive and stretch length
  input wire logic i_oe_n,
  input wire logic [3:0] i_hold,
  // resolved line
  output logic o_scl
);
  logic [3:0] cnt_r;
  logic oe_prev_r;
  logic hold_w;

  // slave holds SCL low for i_hold cycles after the device releases it
  assign hold_w = (cnt_r != 4'h0) || (i_oe_n && !oe_prev_r && (i_hold != 4'h0));
  assign o_scl = !((i_oe_n === 1'b0) || hold_w);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_r <= 4'h0;
      oe_prev_r <= 1'b1;
    end else begin
      oe_prev_r <= i_oe_n;
      if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (i_oe_n && !oe_prev_r && (i_hold != 4'h0)) begin
        cnt_r <= i_hold - 4'h1;
      end
    end
  end
endmodule : scl_partner

`default_nettype wire

// file: tb/i2c_ctrl_top_tb.sv
/*
  Register-level bench of the address match, SCL generator and clear block.
  Assumes the design's register map constants and a partner on the SCL line.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.svh"

module i2c_ctrl_top_tb;
  import i2c_ctrl_pkg::*;
  logic i_clock, i_reset, i_wr, i_rd, i_master_mode, i_clock_run;
  logic i_addr_valid, i_state_change, i_stop_seen, i_scl_in;
  word_t i_addr, i_wdata, o_rdata, rd_v, expv;
  logic [7:0] i_addr_byte;
  logic [3:0] hold;
  logic o_irq, o_ack_flag, o_irq_flag, o_start_flag, o_stop_flag, o_iface_en;
  logic o_addr_hit, o_gc_hit, o_ack_addr, o_addressed, o_scl_out, o_scl_oe_n;
  int n_errors, comparisons, lo, hi;
  int bits[4] = '{2, 3, 5, 6};

  i2c_ctrl_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_master_mode(i_master_mode), .i_clock_run(i_clock_run),
    .i_addr_valid(i_addr_valid), .i_addr_byte(i_addr_byte),
    .i_state_change(i_state_change), .i_stop_seen(i_stop_seen),
    .o_ack_flag(o_ack_flag), .o_irq_flag(o_irq_flag), .o_start_flag(o_start_flag),
    .o_stop_flag(o_stop_flag), .o_iface_en(o_iface_en), .o_addr_hit(o_addr_hit),
    .o_gc_hit(o_gc_hit), .o_ack_addr(o_ack_addr), .o_addressed(o_addressed),
    .i_scl_in(i_scl_in), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n));

  scl_partner far (.i_clock(i_clock), .i_reset(i_reset), .i_oe_n(o_scl_oe_n),
    .i_hold(hold), .o_scl(i_scl_in));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input word_t a, input word_t d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input word_t a, output word_t d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
  endtask : rd

  task automatic rdc(input word_t a, input word_t exp);
    word_t d;
    rd(a, d);
    check(d, exp);
  endtask : rdc

  // received address byte, then the match pulses one cycle later
  task automatic match(input logic [7:0] b, input logic hit, input logic gc);
    @(posedge i_clock);
    i_addr_valid <= 1'b1;
    i_addr_byte <= b;
    @(posedge i_clock);
    i_addr_valid <= 1'b0;
    @(negedge i_clock);
    check({30'h0, o_addr_hit, o_gc_hit}, {30'h0, hit, gc});
  endtask : match

  // length of the next phase with oe_n at lvl
  task automatic meas(input logic lvl, output int n);
    int w;
    w = 0;
    while (o_scl_oe_n !== lvl && w < 2000) begin
      @(negedge i_clock);
      w++;
    end
    n = 0;
    while (o_scl_oe_n === lvl && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
    if (w >= 2000 || n >= 2000) begin
      n_errors++;
      conclude();
    end
  endtask : meas

  initial begin
    {i_wr, i_rd, i_master_mode, i_clock_run, i_addr_valid} = 5'h0;
    {i_state_change, i_stop_seen} = 2'h0;
    i_addr = 32'h0000_0000;
    i_wdata = 32'h0000_0000;
    i_addr_byte = 8'h00;
    hold = 4'h0;
    i_reset = 1'b1;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    rdc(`SLAVE_ADDR0_ADDR, 32'h0000_0000);
    rdc(`SCL_HIGH_ADDR, 32'h0000_0004);
    rdc(`SCL_LOW_ADDR, 32'h0000_0004);
    rdc(32'h4000_0004, 32'h0000_0000);
    // clear one flag at a time, reserved bits written zero
    wr(`CTRL_SET_ADDR, 32'h0000_006C);
    expv = 32'h0000_006C;
    for (int i = 0; i < 4; i++) begin
      wr(`CTRL_CLEAR_ADDR, 32'h1 << bits[i]);
      expv = expv & ~(32'h1 << bits[i]);
      rdc(`CTRL_SET_ADDR, expv);
      check({28'h0, o_iface_en, o_start_flag, o_irq_flag, o_ack_flag},
        {28'h0, expv[6], expv[5], expv[3], expv[2]});
    end
    wr(`CTRL_SET_ADDR, 32'h0000_0044);
    wr(`IRQ_ENABLE_ADDR, 32'h0000_0001);
    wr(`SLAVE_ADDR0_ADDR, 32'h0000_0052);
    rdc(`SLAVE_ADDR0_ADDR, 32'h0000_0052);
    match(8'h53, 1'b1, 1'b0);
    check({31'h0, o_ack_addr}, 32'h1);
    @(negedge i_clock);
    check({30'h0, o_addressed, o_irq}, 32'h3);
    rdc(`IRQ_STATUS_ADDR, 32'h0000_0001);
    @(posedge i_clock);
    i_stop_seen <= 1'b1;
    @(posedge i_clock);
    i_stop_seen <= 1'b0;
    wr(`IRQ_CLEAR_ADDR, 32'h0000_0007);
    rdc(`IRQ_STATUS_ADDR, 32'h0000_0000);
    check({30'h0, o_addressed, o_irq}, 32'h0);
    wr(`IRQ_ENABLE_ADDR, 32'h0000_0000);
    match(8'h52, 1'b1, 1'b0);
    @(negedge i_clock);
    check({31'h0, o_irq}, 32'h0);
    match(8'h00, 1'b0, 1'b0);
    wr(`SLAVE_ADDR0_ADDR, 32'h0000_0053);
    match(8'h00, 1'b0, 1'b1);
    @(posedge i_clock);
    i_master_mode <= 1'b1;
    match(8'h52, 1'b0, 1'b0);
    @(posedge i_clock);
    i_master_mode <= 1'b0;
    wr(`SLAVE_ADDR0_ADDR, 32'h0000_0000);
    match(8'h00, 1'b0, 1'b0);
    wr(`SLAVE_ADDR0_ADDR, 32'h0000_0052);
    // stop request taken while enabled, then dropped by the disable
    wr(`CTRL_SET_ADDR, 32'h0000_0010);
    rdc(`CTRL_SET_ADDR, 32'h0000_0054);
    check({31'h0, o_stop_flag}, 32'h1);
    wr(`CTRL_CLEAR_ADDR, 32'h0000_0040);
    rdc(`CTRL_SET_ADDR, 32'h0000_0004);
    match(8'h52, 1'b0, 1'b0);
    wr(`CTRL_SET_ADDR, 32'h0000_0010);
    @(negedge i_clock);
    check({31'h0, o_stop_flag}, 32'h0);
    // asymmetric clock, counts at least 4
    wr(`SCL_HIGH_ADDR, 32'h0000_0006);
    wr(`SCL_LOW_ADDR, 32'h0000_0004);
    wr(`CTRL_SET_ADDR, 32'h0000_0040);
    @(posedge i_clock);
    i_master_mode <= 1'b1;
    i_clock_run <= 1'b1;
    meas(1'b0, lo);
    meas(1'b1, hi);
    check(lo, 4);
    check(hi, 6);
    check(lo + hi, 10);
    @(posedge i_clock);
    hold <= 4'h3;
    meas(1'b0, lo);
    meas(1'b1, hi);
    check(hi, 9);
    @(posedge i_clock);
    hold <= 4'h0;
    wr(`CTRL_SET_ADDR, 32'h0000_0008);
    repeat (20) @(negedge i_clock);
    check({31'h0, o_scl_oe_n}, 32'h0);
    wr(`CTRL_CLEAR_ADDR, 32'h0000_0008);
    meas(1'b1, hi);
    meas(1'b0, lo);
    check(hi, 6);
    check(lo, 4);
    check({31'h0, o_scl_out}, 32'h0);
    // engine state change sets the interrupt flag, which holds SCL low
    @(posedge i_clock);
    i_state_change <= 1'b1;
    @(posedge i_clock);
    i_state_change <= 1'b0;
    repeat (12) @(negedge i_clock);
    check({30'h0, o_irq_flag, o_scl_oe_n}, 32'h0000_0002);
    // a clear in the cycle of a new event loses
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= `CTRL_CLEAR_ADDR;
    i_wdata <= 32'h0000_0008;
    i_state_change <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_state_change <= 1'b0;
    @(negedge i_clock);
    check({31'h0, o_irq_flag}, 32'h1);
    wr(`CTRL_CLEAR_ADDR, 32'h0000_0008);
    @(negedge i_clock);
    check({31'h0, o_irq_flag}, 32'h0);
    conclude();
  end
endmodule : i2c_ctrl_top_tb

`default_nettype wire
